/* rtl/enclave_page_accept_copy.v */
// Accept-copy engine: checks, descriptor fetch, page copy, map update
// Contract
// (RULE1) Leaf 07H, only inside an enclave
// (RULE2) Destination augmented pending page, source regular page
// (RULE3) Descriptor not 64-byte aligned: GP
// (RULE4) Page pointers not 4 KB aligned: GP
// (RULE5) Any address outside enclave range: GP
// (RULE6) Not in protected memory: PF, ordered
// (RULE7) Descriptor page attributes wrong: PF
// (RULE8) Copy descriptor into 512-bit scratch
// (RULE9) Bad reserved, W without R, type: GP
// (RULE10) Source page attributes wrong: PF
// (RULE11) Destination mismatch: ZF, mismatch code, done
// (RULE12) Destination page in use: GP
// (RULE13) Destination recheck fails: PF
// (RULE14) Copy all 4096 source bytes
// (RULE15) OR permissions in, clear pending
// (RULE16) Success clears ZF, result zero; clear others
// (RULE17) Segment limit, misaligned, locked: GP
// (RULE18) 64-bit noncanonical, misaligned, locked: GP
// (RULE19) Access or attribute problems give PF
// (RULE20) No overlap with same-page modify leaves
// (RULE21) First failing check ends, nothing modified
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "accept_copy_defines.vh"
module enclave_page_accept_copy #(
	parameter IDX_W = 4
) (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	output reg         memReq,
	output reg         memWe,
	output reg  [31:0] memAddr,
	output reg  [31:0] memWdata,
	input  wire [31:0] memRdata,
	input  wire        memAck,
	input  wire        destInUse,
	output reg         busyOut
);
	localparam PAGES     = 1 << IDX_W;
	localparam S_IDLE    = 4'h0;
	localparam S_CHK1    = 4'h1;
	localparam S_DESC    = 4'h2;
	localparam S_CHK2    = 4'h3;
	localparam S_RD      = 4'h4;
	localparam S_WR      = 4'h5;
	localparam S_UPD     = 4'h6;
	localparam S_DONE    = 4'h7;
	localparam S_WAIT    = 4'h8;

	////////////////////////////////////////////////////////////////
	reg [31:0]  leaf_ff;
	reg [31:0]  descPtr_ff;
	reg [31:0]  dstPtr_ff;
	reg [31:0]  srcPtr_ff;
	reg [31:0]  rangeBase_ff;
	reg [31:0]  rangeLimit_ff;
	reg [31:0]  protBase_ff;
	reg [1:0]   enclaveId_ff;
	reg [4:0]   mode_ff;
	reg [31:0]  result_ff;
	reg         zf_ff;
	reg         done_ff;
	reg [1:0]   fault_ff;
	reg [31:0]  faultAddr_ff;
	reg [IDX_W-1:0] mapIdx_ff;
	reg [31:0]  pageMap [0:PAGES-1];
	reg [511:0] scratch_ff;
	reg [3:0]   state_ff;
	reg [10:0]  cnt_ff;
	reg [31:0]  copyData_ff;
	reg         wrPend_ff;
	reg [7:0]   wrOfs_ff;
	reg         startPulse;
	wire        busySync;
	integer     i;

	pin_sync3 u_busy_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.pinIn    (destInUse),
		.levelOut (busySync)
	);

	////////////////////////////////////////////////////////////////
	// Address decode into protected memory and page map
	wire [31:0] offD = descPtr_ff - protBase_ff;
	wire [31:0] offX = dstPtr_ff - protBase_ff;
	wire [31:0] offS = srcPtr_ff - protBase_ff;
	wire inD = (descPtr_ff >= protBase_ff) && (offD[31:12] < PAGES); // [RULE6]
	wire inX = (dstPtr_ff >= protBase_ff) && (offX[31:12] < PAGES);
	wire inS = (srcPtr_ff >= protBase_ff) && (offS[31:12] < PAGES);
	wire [31:0] entD = pageMap[offD[12+IDX_W-1:12]];
	wire [31:0] entX = pageMap[offX[12+IDX_W-1:12]];
	wire [31:0] entS = pageMap[offS[12+IDX_W-1:12]];
	wire [2:0]  ptD = entD[`PM_TYPE_HI:`PM_TYPE_LO];
	wire [2:0]  ptX = entX[`PM_TYPE_HI:`PM_TYPE_LO];
	wire [2:0]  ptS = entS[`PM_TYPE_HI:`PM_TYPE_LO];
	wire [7:0]  reqType = scratch_ff[`DS_TYPE_HI:`DS_TYPE_LO];

	wire rngD = descPtr_ff >= rangeBase_ff && descPtr_ff <= rangeLimit_ff;
	wire rngX = dstPtr_ff >= rangeBase_ff && dstPtr_ff <= rangeLimit_ff;
	wire rngS = srcPtr_ff >= rangeBase_ff && srcPtr_ff <= rangeLimit_ff;

	// Descriptor page: valid, readable, settled, regular, ours, mapped
	wire badD = !entD[`PM_VALID] || !entD[`PM_READ] || entD[`PM_PENDING]
		|| entD[`PM_MODIFIED] || entD[`PM_BLOCKED]
		|| ({5'h00, ptD} != `TYPE_REGULAR)
		|| (entD[`PM_OWNER_HI:`PM_OWNER_LO] != enclaveId_ff)
		|| (entD[31:12] != descPtr_ff[31:12]); // [RULE7]
	// Source: regular settled page of this enclave
	wire badS = !entS[`PM_VALID] || entS[`PM_PENDING] || entS[`PM_MODIFIED]
		|| entS[`PM_BLOCKED] || ({5'h00, ptS} != `TYPE_REGULAR)
		|| (entS[`PM_OWNER_HI:`PM_OWNER_LO] != enclaveId_ff)
		|| (entS[31:12] != srcPtr_ff[31:12]); // [RULE10] [RULE2]
	// Destination first look: augmented and still pending
	wire missX = !entX[`PM_VALID] || !entX[`PM_PENDING] || entX[`PM_MODIFIED]
		|| ({5'h00, ptX} != `TYPE_REGULAR)
		|| (entX[`PM_OWNER_HI:`PM_OWNER_LO] != enclaveId_ff); // [RULE11] [RULE2]
	// Destination recheck after gaining the page
	wire badX = !entX[`PM_VALID] || !entX[`PM_PENDING] || entX[`PM_MODIFIED]
		|| !entX[`PM_READ] || !entX[`PM_WRITE] || entX[`PM_EXEC]
		|| ({5'h00, ptX} != reqType)
		|| (entX[`PM_OWNER_HI:`PM_OWNER_LO] != enclaveId_ff)
		|| (entX[31:12] != dstPtr_ff[31:12]); // [RULE13]
	wire badFlags = (scratch_ff[511:16] != 496'h0) || (scratch_ff[7:3] != 5'h00)
		|| (!scratch_ff[`DS_READ] && scratch_ff[`DS_WRITE])
		|| (reqType != `TYPE_REGULAR); // [RULE9]
	// Operand access faults supplied by the core
	wire addrGp = mode_ff[`MODE_64BIT] ? mode_ff[`MODE_NONCANON]
		: mode_ff[`MODE_SEG_LIMIT]; // [RULE17] [RULE18]

	////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states
	wire addrPhase = hsel && hready && htrans[1];
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wrPend_ff <= 1'b0;
			wrOfs_ff  <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wrPend_ff <= addrPhase && hwrite;
			wrOfs_ff  <= haddr[7:0];
			if (addrPhase && !hwrite) begin
				case (haddr[7:0])
				`OFS_CTRL:        hrdata <= {31'h0, busyOut};
				`OFS_LEAF:        hrdata <= leaf_ff;
				`OFS_DESC_PTR:    hrdata <= descPtr_ff;
				`OFS_DST_PTR:     hrdata <= dstPtr_ff;
				`OFS_SRC_PTR:     hrdata <= srcPtr_ff;
				`OFS_RANGE_BASE:  hrdata <= rangeBase_ff;
				`OFS_RANGE_LIMIT: hrdata <= rangeLimit_ff;
				`OFS_PROT_BASE:   hrdata <= protBase_ff;
				`OFS_ENCLAVE_ID:  hrdata <= {30'h0, enclaveId_ff};
				`OFS_MODE:        hrdata <= {27'h0, mode_ff};
				`OFS_RESULT:      hrdata <= result_ff;
				// Carry, parity, aux, overflow, sign always read zero
				`OFS_STATUS:      hrdata <= {24'h0, zf_ff, 1'b0, fault_ff,
					2'b00, done_ff, busyOut}; // [RULE16]
				`OFS_FAULT_ADDR:  hrdata <= faultAddr_ff;
				`OFS_MAP_INDEX:   hrdata <= {{(32-IDX_W){1'b0}}, mapIdx_ff};
				`OFS_MAP_DATA:    hrdata <= pageMap[mapIdx_ff];
				default:          hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Operand registers are frozen while an operation runs
	wire swWr = wrPend_ff && !busyOut;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			leaf_ff       <= 32'h00000000;
			descPtr_ff    <= 32'h00000000;
			dstPtr_ff     <= 32'h00000000;
			srcPtr_ff     <= 32'h00000000;
			rangeBase_ff  <= 32'h00000000;
			rangeLimit_ff <= 32'h00000000;
			protBase_ff   <= 32'h00000000;
			enclaveId_ff  <= 2'h0;
			mode_ff       <= 5'h00;
			mapIdx_ff     <= {IDX_W{1'b0}};
			startPulse    <= 1'b0;
		end else begin
			startPulse <= swWr && (wrOfs_ff == `OFS_CTRL) && hwdata[0];
			if (swWr) begin
				case (wrOfs_ff)
				`OFS_LEAF:        leaf_ff <= hwdata;
				`OFS_DESC_PTR:    descPtr_ff <= hwdata;
				`OFS_DST_PTR:     dstPtr_ff <= hwdata;
				`OFS_SRC_PTR:     srcPtr_ff <= hwdata;
				`OFS_RANGE_BASE:  rangeBase_ff <= hwdata;
				`OFS_RANGE_LIMIT: rangeLimit_ff <= hwdata;
				`OFS_PROT_BASE:   protBase_ff <= hwdata;
				`OFS_ENCLAVE_ID:  enclaveId_ff <= hwdata[1:0];
				`OFS_MODE:        mode_ff <= hwdata[4:0];
				`OFS_MAP_INDEX:   mapIdx_ff <= hwdata[IDX_W-1:0];
				default:          ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Page map storage; engine update has the only write while busy
	wire [IDX_W-1:0] dstIdx = offX[12+IDX_W-1:12];
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (i = 0; i < PAGES; i = i + 1) begin
				pageMap[i] <= 32'h00000000;
			end
		end else if (state_ff == S_UPD) begin
			pageMap[dstIdx] <= (entX | {28'h0, scratch_ff[2:0], 1'b0})
				& ~(32'h1 << `PM_PENDING); // [RULE15]
		end else if (swWr && wrOfs_ff == `OFS_MAP_DATA) begin
			pageMap[mapIdx_ff] <= hwdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Engine
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff     <= S_IDLE;
			busyOut      <= 1'b0;
			done_ff      <= 1'b0;
			fault_ff     <= `FAULT_NONE;
			faultAddr_ff <= 32'h00000000;
			result_ff    <= 32'h00000000;
			zf_ff        <= 1'b0;
			scratch_ff   <= 512'h0;
			cnt_ff       <= 11'h000;
			copyData_ff  <= 32'h00000000;
			memReq       <= 1'b0;
			memWe        <= 1'b0;
			memAddr      <= 32'h00000000;
			memWdata     <= 32'h00000000;
		end else begin
			case (state_ff)
			S_IDLE: begin
				if (startPulse) begin
					busyOut  <= 1'b1;
					done_ff  <= 1'b0;
					fault_ff <= `FAULT_NONE;
					state_ff <= S_CHK1;
				end
			end
			S_CHK1: begin
				// Strict priority; first failure ends the run untouched [RULE21]
				state_ff <= S_DONE;
				if (leaf_ff != `LEAF_ACCEPT_COPY || !mode_ff[`MODE_IN_ENCL]) begin
					fault_ff <= `FAULT_GP; // [RULE1]
				end else if (mode_ff[`MODE_LOCKED] || addrGp) begin
					fault_ff <= `FAULT_GP; // [RULE17] [RULE18]
				end else if ((descPtr_ff & `DESC_ALIGN_MASK) != 32'h0) begin
					fault_ff <= `FAULT_GP; // [RULE3]
				end else if (((dstPtr_ff | srcPtr_ff) & `PAGE_ALIGN_MASK) != 32'h0) begin
					fault_ff <= `FAULT_GP; // [RULE4]
				end else if (!rngD || !rngX || !rngS) begin
					fault_ff <= `FAULT_GP; // [RULE5]
				end else if (!inD) begin
					fault_ff     <= `FAULT_PF; // [RULE6]
					faultAddr_ff <= descPtr_ff;
				end else if (!inX) begin
					fault_ff     <= `FAULT_PF; // [RULE6]
					faultAddr_ff <= dstPtr_ff;
				end else if (!inS) begin
					fault_ff     <= `FAULT_PF; // [RULE6]
					faultAddr_ff <= srcPtr_ff;
				end else if (badD) begin
					// Residency of all three operands outranks descriptor attributes
					fault_ff     <= `FAULT_PF; // [RULE7] [RULE19]
					faultAddr_ff <= descPtr_ff;
				end else begin
					cnt_ff   <= 11'h000;
					memReq   <= 1'b1;
					memWe    <= 1'b0;
					memAddr  <= descPtr_ff;
					state_ff <= S_DESC;
				end
			end
			S_DESC: begin
				if (memAck) begin
					scratch_ff <= {memRdata, scratch_ff[511:32]}; // [RULE8]
					if (cnt_ff == `DESC_WORDS - 1) begin
						memReq   <= 1'b0;
						state_ff <= S_CHK2;
					end else begin
						memAddr <= memAddr + 32'h4;
						cnt_ff  <= cnt_ff + 11'h001;
					end
				end
			end
			S_CHK2: begin
				state_ff <= S_DONE;
				if (badFlags) begin
					fault_ff <= `FAULT_GP; // [RULE9]
				end else if (badS) begin
					fault_ff     <= `FAULT_PF; // [RULE10] [RULE19]
					faultAddr_ff <= srcPtr_ff;
				end else if (missX) begin
					zf_ff     <= 1'b1; // [RULE11]
					result_ff <= `ATTR_MISMATCH;
				end else if (busySync) begin
					// Another modify leaf holds this page [RULE20]
					fault_ff <= `FAULT_GP; // [RULE12]
				end else begin
					state_ff <= S_WAIT;
				end
			end
			S_WAIT: begin
				// Recheck one cycle after gaining the page
				if (badX) begin
					fault_ff     <= `FAULT_PF; // [RULE13] [RULE19]
					faultAddr_ff <= dstPtr_ff;
					state_ff     <= S_DONE;
				end else begin
					cnt_ff   <= 11'h000;
					memReq   <= 1'b1;
					memWe    <= 1'b0;
					memAddr  <= srcPtr_ff;
					state_ff <= S_RD;
				end
			end
			S_RD: begin
				if (memAck) begin
					copyData_ff <= memRdata;
					memWdata    <= memRdata;
					memWe       <= 1'b1;
					memAddr     <= dstPtr_ff + {20'h0, cnt_ff[9:0], 2'b00};
					state_ff    <= S_WR;
				end
			end
			S_WR: begin
				if (memAck) begin
					if (cnt_ff == `PAGE_WORDS - 1) begin
						memReq   <= 1'b0;
						memWe    <= 1'b0;
						state_ff <= S_UPD; // [RULE14]
					end else begin
						cnt_ff   <= cnt_ff + 11'h001;
						memWe    <= 1'b0;
						memAddr  <= srcPtr_ff + {20'h0, cnt_ff[9:0] + 10'h001, 2'b00};
						state_ff <= S_RD;
					end
				end
			end
			S_UPD: begin
				zf_ff     <= 1'b0; // [RULE16]
				result_ff <= 32'h00000000;
				state_ff  <= S_DONE;
			end
			S_DONE: begin
				busyOut  <= 1'b0;
				done_ff  <= 1'b1;
				state_ff <= S_IDLE;
			end
			default: state_ff <= S_IDLE;
			endcase
		end
	end
endmodule

/* inc/accept_copy_defines.vh */
// Constants for the protected page accept-copy engine
`ifndef ACCEPT_COPY_DEFINES_VH
`define ACCEPT_COPY_DEFINES_VH
// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_LEAF        8'h04
`define OFS_DESC_PTR    8'h08
`define OFS_DST_PTR     8'h0C
`define OFS_SRC_PTR     8'h10
`define OFS_RANGE_BASE  8'h14
`define OFS_RANGE_LIMIT 8'h18
`define OFS_PROT_BASE   8'h1C
`define OFS_ENCLAVE_ID  8'h20
`define OFS_MODE        8'h24
`define OFS_RESULT      8'h28
`define OFS_STATUS      8'h2C
`define OFS_FAULT_ADDR  8'h30
`define OFS_MAP_INDEX   8'h34
`define OFS_MAP_DATA    8'h38
// Mode register bits
`define MODE_IN_ENCL    0
`define MODE_64BIT      1
`define MODE_LOCKED     2
`define MODE_NONCANON   3
`define MODE_SEG_LIMIT  4
// Page map entry layout
`define PM_VALID        0
`define PM_READ         1
`define PM_WRITE        2
`define PM_EXEC         3
`define PM_PENDING      4
`define PM_MODIFIED     5
`define PM_BLOCKED      6
`define PM_TYPE_LO      7
`define PM_TYPE_HI      9
`define PM_OWNER_LO     10
`define PM_OWNER_HI     11
`define PM_LINADDR_LO   12
// Descriptor layout
`define DS_READ         0
`define DS_WRITE        1
`define DS_EXEC         2
`define DS_TYPE_LO      8
`define DS_TYPE_HI      15
// Codes and values
`define LEAF_ACCEPT_COPY 32'h00000007
`define TYPE_REGULAR     8'h01
`define ATTR_MISMATCH    32'h00000013
`define FAULT_NONE       2'h0
`define FAULT_GP         2'h1
`define FAULT_PF         2'h2
`define DESC_ALIGN_MASK  32'h0000003F
`define PAGE_ALIGN_MASK  32'h00000FFF
`define DESC_WORDS       16
`define PAGE_WORDS       1024
`endif

/* rtl/pin_sync3.v */
// Three-stage synchroniser with agreement filter for an outside level
`timescale 1ns/1ns
module pin_sync3 (
	input  wire clk_sys,
	input  wire rst,
	input  wire pinIn,
	output reg  levelOut
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s1_ff    <= 1'b0;
			s2_ff    <= 1'b0;
			s3_ff    <= 1'b0;
			levelOut <= 1'b0;
		end else begin
			s1_ff <= pinIn;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			// Only a settled level is passed on
			if (s2_ff == s3_ff) begin
				levelOut <= s3_ff;
			end
		end
	end
endmodule

/* tb/page_memory_model.sv */
// Protected page memory answering the engine's copy port
`timescale 1ns/1ns
module page_memory_model #(
	parameter logic [31:0] BASE = 32'h0001_0000
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        memReq,
	input  wire logic        memWe,
	input  wire logic [31:0] memAddr,
	input  wire logic [31:0] memWdata,
	input  wire logic [3:0]  waitCycles,
	output logic      [31:0] memRdata,
	output logic             memAck
);
	logic [31:0] mem [0:16383];
	logic [3:0]  cnt_ff;
	logic [13:0] idx;
	assign idx = 14'((memAddr - BASE) >> 2);
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{memAck, cnt_ff, memRdata} <= 37'h0;
		end else begin
			memAck <= 1'b0;
			// Stale data flips so a late capture cannot pass
			memRdata <= ~memRdata;
			if (memReq && !memAck) begin
				if (cnt_ff == waitCycles) begin
					memAck <= 1'b1;
					cnt_ff <= 4'h0;
					if (memWe) mem[idx] <= memWdata;
					else memRdata <= mem[idx];
				end else begin
					cnt_ff <= cnt_ff + 4'h1;
				end
			end
		end
	end
endmodule

/* tb/enclave_page_accept_copy_asserts.sv */
// Checker for the accept-copy engine ports
`timescale 1ns/1ns
`include "accept_copy_defines.vh"
module enclave_page_accept_copy_asserts #(
	parameter IDX_W = 4
) (
	input wire        clk_sys,
	input wire        rst,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [2:0]  hsize,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire        memReq,
	input wire        memWe,
	input wire [31:0] memAddr,
	input wire [31:0] memWdata,
	input wire [31:0] memRdata,
	input wire        memAck,
	input wire        destInUse,
	input wire        busyOut
);
	logic        aw_ff, bsy_ff, fst_ff, held_ff;
	logic [2:0]  inCnt_ff;
	logic [7:0]  aa_ff;
	logic [31:0] dsc_ff, dst_ff, src_ff;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	//////////////////////////////////////////////////
	// Shadow of pointer writes; the bench never writes while busy
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{aw_ff, bsy_ff, fst_ff, held_ff, inCnt_ff, aa_ff} <= 15'h0;
			{dsc_ff, dst_ff, src_ff} <= 96'h0;
		end else begin
			if (hready) begin
				aw_ff <= hsel && htrans[1] && hwrite;
				aa_ff <= haddr[7:0];
			end
			if (aw_ff && aa_ff == `OFS_DESC_PTR) dsc_ff <= hwdata;
			if (aw_ff && aa_ff == `OFS_DST_PTR) dst_ff <= hwdata;
			if (aw_ff && aa_ff == `OFS_SRC_PTR) src_ff <= hwdata;
			bsy_ff <= busyOut;
			fst_ff <= (busyOut && !bsy_ff) || (fst_ff && !memAck);
			if (busyOut && !bsy_ff) held_ff <= &inCnt_ff;
			inCnt_ff <= destInUse ? inCnt_ff + {2'h0, ~&inCnt_ff} : 3'h0;
		end
	end
	//////////////////////////////////////////////////
	a_start_busy: assert property (aw_ff && aa_ff == `OFS_CTRL && hwdata[0] && !busyOut |-> ##[1:4] busyOut)
		else $error("start not taken");
	a_desc_first: assert property (memReq && fst_ff |-> !memWe && memAddr == dsc_ff)
		else $error("first fetch not the descriptor");
	a_copy_pair: assert property (memAck && !memWe && memAddr[31:12] == src_ff[31:12] |=> memReq && memWe && memAddr == {dst_ff[31:12], $past(memAddr[11:0])} && memWdata == $past(memRdata))
		else $error("copy write wrong");
	a_next_src: assert property (memAck && memWe && memAddr[11:0] != 12'hFFC |=> memReq && !memWe && memAddr == {src_ff[31:12], $past(memAddr[11:0]) + 12'h4})
		else $error("next source read wrong");
	a_copy_end: assert property (memAck && memWe && memAddr[11:0] == 12'hFFC |-> ##[1:8] !busyOut)
		else $error("no finish after copy");
	a_req_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
		else $error("request dropped early");
	a_mem_busy: assert property (memReq |-> busyOut)
		else $error("memory access while idle");
	a_in_use: assert property (memReq && memWe |-> !held_ff)
		else $error("write to page in use");
endmodule
bind enclave_page_accept_copy enclave_page_accept_copy_asserts #(.IDX_W(IDX_W)) asrt (
	.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
	.hreadyout, .hresp, .memReq, .memWe, .memAddr, .memWdata, .memRdata, .memAck,
	.destInUse, .busyOut);

/* tb/enclave_page_accept_copy_bench.sv */
// Self-checking bench for the accept-copy engine
`timescale 1ns/1ns
`include "accept_copy_defines.vh"
module enclave_page_accept_copy_bench;
	localparam logic [31:0] DSC = 32'h0001_0040, DST = 32'h0001_2000, SRC = 32'h0001_1000;
	localparam logic [31:0] DSTE = 32'h0001_2497, D = 32'h0000_0107;
	logic        clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic        memReq, memWe, memAck, destInUse, busyOut, expZf;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  waitCycles;
	logic [31:0] haddr, hwdata, hrdata, memAddr, memWdata, memRdata, q, expRes;
	int          fails, comparisons;
	logic [7:0]  cfgOfs [15] = '{`OFS_LEAF, `OFS_DESC_PTR, `OFS_DST_PTR, `OFS_SRC_PTR,
		`OFS_RANGE_BASE, `OFS_RANGE_LIMIT, `OFS_PROT_BASE, `OFS_ENCLAVE_ID, `OFS_MODE,
		`OFS_MAP_INDEX, `OFS_MAP_DATA, `OFS_MAP_INDEX, `OFS_MAP_DATA, `OFS_MAP_INDEX, `OFS_MAP_DATA};
	logic [31:0] cfgVal [15] = '{`LEAF_ACCEPT_COPY, DSC, DST, SRC, 32'h0001_0000, 32'h0002_FFFF,
		32'h0001_0000, 32'h1, 32'h1, 32'h0, 32'h0001_0483, 32'h1, 32'h0001_1483, 32'h2, DSTE};
	assign hready = hreadyout;
	enclave_page_accept_copy uut (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .memReq, .memWe, .memAddr, .memWdata,
		.memRdata, .memAck, .destInUse, .busyOut);
	page_memory_model mdl (.clk_sys, .rst, .memReq, .memWe, .memAddr, .memWdata,
		.waitCycles, .memRdata, .memAck);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	//////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, 24'h0, a};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {3'h0, d};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
		bus(1'b0, a, 32'h0);
		chk(q, exp, m);
	endtask
	// Fault code 3 stands for the attribute-mismatch completion
	task automatic runCase(input logic [7:0] ofs, input logic [31:0] val, input logic [1:0] idx,
		input logic [31:0] ent, input logic [31:0] dw0, input logic [1:0] flt, input logic [31:0] fa);
		int n;
		destInUse <= (ofs == 8'hFC);
		for (int i = 0; i < 1024; i++) begin
			mdl.mem[2048 + i] = 32'h0;
			mdl.mem[1024 + i] = 32'hA500_0000 | i;
			if (i < 16) mdl.mem[16 + i] = (i == 0) ? dw0 : 32'h0;
		end
		for (int i = 0; i < 15; i++) wr(cfgOfs[i], cfgVal[i]);
		wr(ofs, val);
		wr(`OFS_MAP_INDEX, {30'h0, idx});
		wr(`OFS_MAP_DATA, ent);
		wr(`OFS_CTRL, 32'h1);
		repeat (4) @(posedge clk_sys);
		n = 0;
		do begin
			bus(1'b0, `OFS_STATUS, 32'h0);
			n++;
		end while (q[1] !== 1'b1 && n < 4000);
		// Faults leave ZF and the result as the last completion set them
		if (flt == 2'h3) {expZf, expRes} = {1'b1, `ATTR_MISMATCH};
		if (flt == 2'h0) {expZf, expRes} = 33'h0;
		chk(q, {24'h0, expZf, 1'b0, flt == 2'h3 ? 2'h0 : flt, 4'h2}, "status");
		rd(`OFS_RESULT, expRes, "result");
		if (flt == `FAULT_PF) rd(`OFS_FAULT_ADDR, fa, "fault address");
		wr(`OFS_MAP_INDEX, {30'h0, idx});
		rd(`OFS_MAP_DATA, flt == 2'h0 ? (ent | {28'h0, dw0[2:0], 1'b0}) & ~32'h10 : ent, "entry");
		for (int i = 0; i < 1024; i++) begin
			if (flt == 2'h0 || i == 0) chk(mdl.mem[2048 + i], flt == 2'h0 ? 32'hA500_0000 | i : 32'h0, "copy");
		end
	endtask
	task automatic gp(input logic [7:0] ofs, input logic [31:0] val, input logic [31:0] dw0);
		runCase(ofs, val, 2'h2, DSTE, dw0, `FAULT_GP, 32'h0);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////
	initial begin
		#1_200_000;
		fails++;
		print_verdict();
	end
	initial begin
		{rst, hsel, hwrite, destInUse, htrans, hsize, waitCycles} = 13'h1022;
		{haddr, hwdata, expRes, expZf} = 97'h0;
		fails = 0;
		comparisons = 0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`OFS_STATUS, 32'h0, "status at reset");
		wr(`OFS_RESULT, 32'h55);
		rd(`OFS_RESULT, 32'h0, "result read only");
		rd(`OFS_MAP_DATA, 32'h0, "map at reset");
		gp(`OFS_LEAF, 32'h6, D);
		gp(`OFS_MODE, 32'h0, D);
		gp(`OFS_MODE, 32'h5, D);
		gp(`OFS_MODE, 32'h11, D);
		gp(`OFS_MODE, 32'hB, D);
		gp(`OFS_DESC_PTR, 32'h0001_0020, D);
		gp(`OFS_DST_PTR, 32'h0001_2800, D);
		gp(`OFS_SRC_PTR, 32'h0001_1004, D);
		gp(`OFS_RANGE_LIMIT, 32'h0001_1FFF, D);
		gp(`OFS_RANGE_BASE, 32'h0001_0041, D);
		gp(8'hFC, 32'h0, D);
		gp(`OFS_MODE, 32'h1, 32'h108);
		gp(`OFS_MODE, 32'h1, 32'h102);
		gp(`OFS_MODE, 32'h1, 32'h207);
		runCase(`OFS_PROT_BASE, 32'h0001_1000, 2'h2, DSTE, D, `FAULT_PF, DSC);
		runCase(`OFS_DST_PTR, 32'h0002_0000, 2'h2, DSTE, D, `FAULT_PF, 32'h0002_0000);
		runCase(`OFS_SRC_PTR, 32'h0002_1000, 2'h2, DSTE, D, `FAULT_PF, 32'h0002_1000);
		runCase(`OFS_MODE, 32'h1, 2'h0, 32'h0001_0481, D, `FAULT_PF, DSC);
		runCase(`OFS_DST_PTR, 32'h0002_0000, 2'h0, 32'h0001_0481, D, `FAULT_PF, 32'h0002_0000);
		runCase(`OFS_ENCLAVE_ID, 32'h2, 2'h2, DSTE, D, `FAULT_PF, DSC);
		runCase(`OFS_MODE, 32'h1, 2'h1, 32'h0001_1493, D, `FAULT_PF, SRC);
		runCase(`OFS_MODE, 32'h1, 2'h2, 32'h0001_2487, D, 2'h3, 32'h0);
		runCase(`OFS_MODE, 32'h1, 2'h2, 32'h0001_2493, D, `FAULT_PF, DST);
		runCase(`OFS_MODE, 32'h1, 2'h2, 32'h0001_249F, D, `FAULT_PF, DST);
		runCase(`OFS_MODE, 32'h1, 2'h2, DSTE, D, 2'h0, 32'h0);
		waitCycles <= 4'h3;
		runCase(`OFS_MODE, 32'h1, 2'h2, DSTE, 32'h101, 2'h0, 32'h0);
		print_verdict();
	end
endmodule
